// ---- rtl/urxps_cfg.svh ----
// constants of the receive phy select block
`ifndef URXPS_CFG_SVH
`define URXPS_CFG_SVH
`define URXPS_ADDR_W 5
`define URXPS_DATA_W 8
`define URXPS_NUM_PHY 31
`define URXPS_FCO_IDLE 1'h1
`define URXPS_ADDR_RST 5'h00
`endif

// ---- rtl/urxps_pkg.sv ----
// types of the receive phy select block
package urxps_pkg;
    typedef enum logic [2:0] {ST_OFF, ST_SPHY, ST_POLL, ST_SEL_HI, ST_SEL_LO, ST_CELL} urxps_state_t;
endpackage

// ---- rtl/urxps_sel_if.sv ----
// select request carrier between poll logic and pin stage
`timescale 1ns/1ps
interface urxps_sel_if #(parameter int AW = 5);
    logic [AW-1:0] addr;
    logic fco;
    logic drive;
    modport src (output addr, output fco, output drive);
    modport dst (input addr, input fco, input drive);
endinterface

// ---- rtl/urxps_pins.sv ----
// registered pin stage for address and flow control
`timescale 1ns/1ps
`include "urxps_cfg.svh"
module urxps_pins #(
    parameter int AW = 5
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // request
    urxps_sel_if.dst sel,
    // pins
    output logic [AW-1:0] addr_o,
    output logic [AW-1:0] addr_oe,
    output logic fco_o,
    output logic fco_oe
);
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            addr_o <= AW'(`URXPS_ADDR_RST);
            fco_o <= `URXPS_FCO_IDLE;
            addr_oe <= '0;
            fco_oe <= 1'b0;
        end else begin
            addr_o <= sel.addr;
            fco_o <= sel.fco;
            addr_oe <= {AW{sel.drive}};
            fco_oe <= sel.drive;
        end
    end

    a_float_in_reset: assert property (@(posedge clk_sys) srst |=> !fco_oe && addr_oe == '0)
        else $error("pins driven after reset");
endmodule // urxps_pins

// ---- rtl/urxps_rx_phy_select.sv ----
// receive phy polling, selection and cell capture
`timescale 1ns/1ps
`include "urxps_cfg.svh"
module urxps_rx_phy_select #(
    parameter int AW = `URXPS_ADDR_W,
    parameter int DW = `URXPS_DATA_W,
    parameter int NUM_PHY = `URXPS_NUM_PHY
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // software control
    input wire logic if_enable,
    input wire logic multi_phy,
    input wire logic accept_ready,
    // phy side
    input wire logic [DW-1:0] rx_input_data,
    input wire logic rx_start_of_cell,
    input wire logic rx_cell_avail,
    output logic [AW-1:0] rx_phy_addr_o,
    output logic [AW-1:0] rx_phy_addr_oe,
    output logic rx_flow_ctrl_out_o,
    output logic rx_flow_ctrl_out_oe,
    // user side
    output logic [DW-1:0] rx_cell_data,
    output logic rx_cell_valid,
    output logic rx_cell_sop,
    output logic [AW-1:0] rx_cell_phy
);
    // the link fixes the address at five bits; address 31 stays out of the poll walk as the null address
    if (AW != 5 || NUM_PHY < 1 || NUM_PHY > 31 || DW < 1) begin : g_param_check
        $error("unsupported parameters");
    end

    urxps_pkg::urxps_state_t state_reg;
    urxps_pkg::urxps_state_t state_next;
    logic [AW-1:0] poll_reg;
    logic [AW-1:0] sel_reg;
    logic fco_next;
    logic [AW-1:0] addr_next;
    logic enabled;

    urxps_sel_if #(.AW(AW)) sel_bus ();

    // =========================================
    // sequencing
    // =========================================
    // a cell ends when the phy withdraws; a single-cycle lag in cell_avail is tolerated by re-polling
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            urxps_pkg::ST_OFF: if (if_enable) state_next = multi_phy ? urxps_pkg::ST_POLL : urxps_pkg::ST_SPHY;
            urxps_pkg::ST_SPHY: if (!if_enable || multi_phy) state_next = urxps_pkg::ST_OFF;
            urxps_pkg::ST_POLL: begin
                if (!if_enable || !multi_phy) state_next = urxps_pkg::ST_OFF;
                else if (rx_cell_avail && accept_ready) state_next = urxps_pkg::ST_SEL_HI;
            end
            urxps_pkg::ST_SEL_HI: state_next = urxps_pkg::ST_SEL_LO;
            urxps_pkg::ST_SEL_LO: state_next = urxps_pkg::ST_CELL;
            urxps_pkg::ST_CELL: begin
                if (!if_enable || !multi_phy) state_next = urxps_pkg::ST_OFF;
                else if (!rx_cell_avail || !accept_ready) state_next = urxps_pkg::ST_POLL;
            end
            default: state_next = urxps_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) state_reg <= urxps_pkg::ST_OFF;
        else state_reg <= state_next;
    end

    // poll address walks 0..NUM_PHY-1; the polled address is latched when a phy answers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            poll_reg <= AW'(`URXPS_ADDR_RST);
            sel_reg <= AW'(`URXPS_ADDR_RST);
        end else if (state_reg == urxps_pkg::ST_POLL) begin
            if (rx_cell_avail && accept_ready) sel_reg <= poll_reg;
            else if (poll_reg == AW'(NUM_PHY - 1)) poll_reg <= '0;
            else poll_reg <= poll_reg + 1'b1;
        end
    end

    // =========================================
    // pin request
    // =========================================
    assign enabled = state_reg != urxps_pkg::ST_OFF;
    always_comb begin
        addr_next = poll_reg;
        fco_next = `URXPS_FCO_IDLE;
        case (state_reg)
            urxps_pkg::ST_SPHY: fco_next = !accept_ready;
            urxps_pkg::ST_SEL_HI: begin
                addr_next = sel_reg;
                fco_next = 1'b1;
            end
            urxps_pkg::ST_SEL_LO, urxps_pkg::ST_CELL: begin
                addr_next = sel_reg;
                fco_next = 1'b0;
            end
            default: begin
                addr_next = poll_reg;
                fco_next = `URXPS_FCO_IDLE;
            end
        endcase
    end
    assign sel_bus.addr = addr_next;
    assign sel_bus.fco = fco_next;
    assign sel_bus.drive = enabled;

    urxps_pins #(.AW(AW)) u_pins (
        .clk_sys(clk_sys),
        .srst(srst),
        .sel(sel_bus),
        .addr_o(rx_phy_addr_o),
        .addr_oe(rx_phy_addr_oe),
        .fco_o(rx_flow_ctrl_out_o),
        .fco_oe(rx_flow_ctrl_out_oe)
    );

    // =========================================
    // cell capture
    // =========================================
    // data is taken in the same cycle that enable is low on the pin, matching phy response latency
    logic fco_low_pin;
    assign fco_low_pin = rx_flow_ctrl_out_oe && !rx_flow_ctrl_out_o;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rx_cell_data <= '0;
            rx_cell_valid <= 1'b0;
            rx_cell_sop <= 1'b0;
            rx_cell_phy <= '0;
        end else begin
            rx_cell_valid <= fco_low_pin;
            rx_cell_sop <= fco_low_pin && rx_start_of_cell;
            if (fco_low_pin) rx_cell_data <= rx_input_data;
            rx_cell_phy <= multi_phy ? rx_phy_addr_o : '0;
        end
    end

    // =========================================
    // checks
    // =========================================
    sequence s_sel_pulse;
        rx_flow_ctrl_out_oe && rx_flow_ctrl_out_o ##1 !rx_flow_ctrl_out_o;
    endsequence

    a_select_pulse: assert property (@(posedge clk_sys) disable iff (srst)
        state_reg == urxps_pkg::ST_SEL_HI |=> s_sel_pulse)
        else $error("select pulse not high then low");
    a_sel_addr_stable: assert property (@(posedge clk_sys) disable iff (srst)
        state_reg == urxps_pkg::ST_SEL_HI |=> rx_phy_addr_o == sel_reg ##1 rx_phy_addr_o == $past(rx_phy_addr_o))
        else $error("select address moved");
    a_poll_range: assert property (@(posedge clk_sys) disable iff (srst)
        poll_reg < AW'(NUM_PHY))
        else $error("poll address out of range");
    a_single_ready: assert property (@(posedge clk_sys) disable iff (srst)
        state_reg == urxps_pkg::ST_SPHY |=> rx_flow_ctrl_out_o == !$past(accept_ready))
        else $error("single-phy ready wrong");
    a_off_float: assert property (@(posedge clk_sys) disable iff (srst)
        !if_enable && state_reg == urxps_pkg::ST_OFF |=> !rx_flow_ctrl_out_oe && rx_phy_addr_oe == '0)
        else $error("pins driven while disabled");
    a_capture_gate: assert property (@(posedge clk_sys) disable iff (srst)
        rx_cell_valid |-> $past(fco_low_pin))
        else $error("capture without enable");
    a_soc_gate: assert property (@(posedge clk_sys) disable iff (srst)
        rx_cell_sop |-> rx_cell_valid && (!multi_phy || rx_cell_phy == $past(sel_reg)))
        else $error("soc outside selection");
    a_mphy_low_only_sel: assert property (@(posedge clk_sys) disable iff (srst)
        multi_phy && fco_low_pin && !$past(fco_low_pin)
            |-> $past(rx_flow_ctrl_out_oe && rx_flow_ctrl_out_o) && $past(rx_phy_addr_o) == rx_phy_addr_o)
        else $error("enable low without select");

    // =========================================
    // sequence checks
    // =========================================
    // state and pins are checked together, so a pin stage that slips by one cycle fails here
    sequence s_poll_hit;
        if_enable && multi_phy && state_reg == urxps_pkg::ST_POLL && rx_cell_avail && accept_ready;
    endsequence
    sequence s_poll_miss;
        state_reg == urxps_pkg::ST_POLL && !(rx_cell_avail && accept_ready);
    endsequence
    sequence s_pin_select;
        rx_flow_ctrl_out_oe && rx_flow_ctrl_out_o && rx_phy_addr_o == sel_reg
            ##1 !rx_flow_ctrl_out_o && rx_phy_addr_o == sel_reg;
    endsequence

    a_hit_latches: assert property (@(posedge clk_sys) disable iff (srst)
        s_poll_hit |=> state_reg == urxps_pkg::ST_SEL_HI && sel_reg == $past(poll_reg))
        else $error("answering phy not latched");

    a_hit_to_pins: assert property (@(posedge clk_sys) disable iff (srst)
        s_poll_hit |-> ##2 s_pin_select)
        else $error("select not shown on the pins");

    a_poll_advance: assert property (@(posedge clk_sys) disable iff (srst)
        s_poll_miss ##0 poll_reg != AW'(NUM_PHY - 1) |=> poll_reg == $past(poll_reg) + 1'b1)
        else $error("poll address did not advance");

    a_poll_wrap: assert property (@(posedge clk_sys) disable iff (srst)
        s_poll_miss ##0 poll_reg == AW'(NUM_PHY - 1) |=> poll_reg == '0)
        else $error("poll address did not wrap");

    a_cell_release: assert property (@(posedge clk_sys) disable iff (srst)
        state_reg == urxps_pkg::ST_CELL && if_enable && multi_phy && !(rx_cell_avail && accept_ready)
            |-> ##2 rx_flow_ctrl_out_o)
        else $error("selection kept after phy withdrew");

    a_oe_all_equal: assert property (@(posedge clk_sys) disable iff (srst)
        rx_phy_addr_oe == {AW{rx_flow_ctrl_out_oe}})
        else $error("pin enables disagree");

    a_enable_drives: assert property (@(posedge clk_sys) disable iff (srst)
        state_reg == urxps_pkg::ST_OFF && if_enable |-> ##2 rx_flow_ctrl_out_oe && rx_phy_addr_oe == {AW{1'b1}})
        else $error("pins not driven after enable");

    a_sphy_capture: assert property (@(posedge clk_sys) disable iff (srst)
        state_reg == urxps_pkg::ST_SPHY && accept_ready |-> ##2 rx_cell_valid)
        else $error("single-phy data not taken");

    a_capture_data: assert property (@(posedge clk_sys) disable iff (srst)
        rx_cell_valid |-> rx_cell_data == $past(rx_input_data))
        else $error("captured word differs from input");
endmodule // urxps_rx_phy_select

// ---- bench/urxps_phy_model.sv ----
// behavioural receive phy answering polls and sending cells when selected
`timescale 1ns/1ps
module urxps_phy_model #(
    parameter int DW = 8
) (
    // clock
    input wire logic clk_sys,
    // bench control
    input wire logic has_cell,
    // pins
    input wire logic fco_pin,
    output logic cell_avail,
    output logic [DW-1:0] data,
    output logic soc
);
    logic [DW-1:0] cnt_reg = '0;
    logic sel_reg = 1'b0;
    assign cell_avail = has_cell;
    always_ff @(posedge clk_sys) begin
        cnt_reg <= cnt_reg + 1'b1;
        sel_reg <= !fco_pin;
    end
    // unselected lines carry the inverted count so stale data never looks valid
    assign data = !fco_pin ? cnt_reg : ~cnt_reg;
    assign soc = !fco_pin && !sel_reg;
endmodule // urxps_phy_model

// ---- bench/tb_top.sv ----
// self-checking bench for the receive phy select block
`timescale 1ns/1ps
module tb_top;
    localparam int NP = 31;
    logic clk_sys = 1'b0, srst = 1'b1, if_enable = 1'b0, multi_phy = 1'b0, accept_ready = 1'b0, has_cell = 1'b0;
    logic [7:0] rx_input_data, rx_cell_data;
    logic rx_start_of_cell, rx_cell_avail, fco_o, fco_oe, rx_cell_valid, rx_cell_sop, fco_pin;
    logic [4:0] addr_o, addr_oe, rx_cell_phy, addr_pin, prev;
    int num_errors = 0, checks_done = 0, cycles = 0;
    // released lines sit at the pull-up level
    assign fco_pin = fco_oe ? fco_o : 1'b1;
    assign addr_pin = (addr_o & addr_oe) | ~addr_oe;
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    urxps_rx_phy_select i_urxps_rx_phy_select (.clk_sys(clk_sys), .srst(srst), .if_enable(if_enable),
        .multi_phy(multi_phy), .accept_ready(accept_ready), .rx_input_data(rx_input_data),
        .rx_start_of_cell(rx_start_of_cell), .rx_cell_avail(rx_cell_avail), .rx_phy_addr_o(addr_o),
        .rx_phy_addr_oe(addr_oe), .rx_flow_ctrl_out_o(fco_o), .rx_flow_ctrl_out_oe(fco_oe),
        .rx_cell_data(rx_cell_data), .rx_cell_valid(rx_cell_valid), .rx_cell_sop(rx_cell_sop),
        .rx_cell_phy(rx_cell_phy));
    urxps_phy_model i_urxps_phy_model (.clk_sys(clk_sys), .has_cell(has_cell), .fco_pin(fco_pin),
        .cell_avail(rx_cell_avail), .data(rx_input_data), .soc(rx_start_of_cell));
    // ==========================================
    // common tasks
    task automatic step(int n = 1);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic restart(logic mode);
        srst = 1'b1;
        if_enable = 1'b0;
        multi_phy = mode;
        step(5);
        srst = 1'b0;
        step(3);
        chk(8'({fco_oe, addr_oe}), 8'h00);
        if_enable = 1'b1;
        step(4);
        chk(8'(fco_oe), 8'h01);
    endtask
    // ==========================================
    // scenarios
    task automatic t_single();
        logic [7:0] exp;
        restart(1'b0);
        for (int i = 0; i < 2; i++) begin
            accept_ready = i[0];
            step(3);
            chk(8'(fco_pin), 8'(!accept_ready));
        end
        exp = rx_input_data;
        step();
        chk({rx_cell_valid, rx_cell_sop, 1'b0, rx_cell_phy}, 8'h80);
        chk(rx_cell_data, exp);
    endtask
    task automatic t_poll();
        restart(1'b1);
        accept_ready = 1'b1;
        for (int i = 0; i < 40; i++) begin
            prev = addr_pin;
            step();
            chk(8'(addr_oe), 8'h1F);
            chk(8'(addr_pin), 8'((prev + 1) % NP));
        end
    endtask
    task automatic t_refuse();
        accept_ready = 1'b0;
        has_cell = 1'b1;
        for (int i = 0; i < 40; i++) begin
            step();
            chk(8'({fco_pin, rx_cell_valid}), 8'h02);
        end
    endtask
    task automatic t_select();
        logic [7:0] exp;
        int n = 0;
        accept_ready = 1'b1;
        do begin
            prev = addr_pin;
            step();
            n++;
        end while (fco_pin !== 1'b0 && n < 100);
        chk(8'(n), 8'h03);
        chk(8'(fco_pin), 8'h00);
        chk(8'(addr_pin), 8'(prev));
        for (int i = 0; i < 4; i++) begin
            exp = rx_input_data;
            step();
            chk({rx_cell_valid, rx_cell_sop, 1'b0, rx_cell_phy}, {1'b1, i == 0, 1'b0, prev});
            chk(rx_cell_data, exp);
        end
        has_cell = 1'b0;
        step(2);
        chk(8'(fco_pin), 8'h01);
    endtask
    // ==========================================
    // run control
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        t_single();
        t_poll();
        t_refuse();
        t_select();
        summarize();
    end
endmodule // tb_top
